// ===== core/cssc_edge.sv
// Two-stage sampler and rising-edge detector for a slow tick input
module cssc_edge (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic tick_in, // Raw slow clock level
  output logic rise // One-cycle pulse on rising edge
);
  logic s1_q, s2_q, s3_q;
  logic s1_d, s2_d, s3_d;

  always_comb begin
    s1_d = tick_in;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Reset high: a pin already high after reset is no edge
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  assign rise = s2_q & ~s3_q;
endmodule

// ===== core/cssc_gate.sv
// Clock domain enable decode from sleep state
module cssc_gate
  import cssc_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic running, // Start-up complete
  input wire logic asleep, // Sleep entered
  input wire cssc_pkg::cssc_sleep_t mode, // Active sleep mode
  output cssc_pkg::cssc_gate_t gate // Registered domain enables
);
  cssc_gate_t gate_q, gate_d;

  always_comb begin
    gate_d = '0;
    if (running) begin
      if (!asleep) begin
        gate_d = '{core: 1'b1, periph: 1'b1, progmem: 1'b1, conv: 1'b1};
      end else begin
        case (mode)
          CSSC_SLEEP_IDLE: begin
            gate_d.periph = 1'b1; // R10
            gate_d.conv = 1'b1;
          end
          CSSC_SLEEP_NOISE: begin
            gate_d.conv = 1'b1; // R12
          end
          default: begin
            gate_d = '0; // R13
          end
        endcase
      end
    end
    gate_d.progmem = gate_d.core; // R11
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_q <= '0;
    end else begin
      gate_q <= gate_d;
    end
  end

  assign gate = gate_q;
endmodule

// ===== core/cssc_map.svh
// Constants for the clock source and start-up control block
`ifndef CSSC_MAP_SVH
`define CSSC_MAP_SVH
// Clock source select codes, fuse value 0 = programmed
`define CSSC_SRC_EXT 4'h0
`define CSSC_SRC_RC8M 4'h2
`define CSSC_SRC_RC128K 4'h4
`define CSSC_SRC_LFXTAL 4'h6
// Start-up codes
`define CSSC_SUT_SHORT 2'h0
`define CSSC_SUT_4MS 2'h1
`define CSSC_SUT_64MS 2'h2
// Cycle counts
`define CSSC_PD_CYCLES 16'h0006
`define CSSC_RST_CYCLES 16'h000E
`define CSSC_WDT_4MS 16'h0200
`define CSSC_WDT_64MS 16'h2000
// Fuse reset values: internal 8 MHz, slow rising power
`define CSSC_SEL_RESET 4'h2
`define CSSC_SUT_RESET 2'h2
`endif

// ===== core/cssc_pkg.sv
// Types for the clock source and start-up control block
package cssc_pkg;
  typedef enum logic [2:0] {
    CSSC_SRC_NONE,
    CSSC_SRC_EXTCLK,
    CSSC_SRC_INT8M,
    CSSC_SRC_INT128K,
    CSSC_SRC_LFX,
    CSSC_SRC_XTAL
  } cssc_src_t;

  typedef struct packed {
    logic [3:0] sel;
    logic [1:0] startup_time_fuses;
  } cssc_fuse_t;

  typedef struct packed {
    logic core;
    logic periph;
    logic progmem;
    logic conv;
  } cssc_gate_t;

  typedef enum logic [1:0] {
    CSSC_SLEEP_IDLE,
    CSSC_SLEEP_NOISE,
    CSSC_SLEEP_STANDBY,
    CSSC_SLEEP_PWRDN
  } cssc_sleep_t;
endpackage

// ===== core/cssc_top.sv
// Clock source select, start-up timing and domain gating
// Operation
// R01: Decode four-bit source select, reserved codes flagged
// R02: Fuse one unprogrammed, zero programmed
// R03: Wake from power-down counts source cycles
// R04: Reset start-up adds watchdog-oscillator delay
// R05: 4 ms is 512, 64 ms 8192 cycles
// R06: External clock: 6 wake, 14 reset cycles
// R07: External clock varies under 2% per cycle
// R08: System holds reset during clock frequency change
// R09: Core clock gates register file and stack
// R10: Peripheral clock drives timers and interrupts
// R11: Program-memory clock follows core clock
// R12: Converter clock runs while core halted
// R13: Sleep mode gates unused clock domains
// R14: Re-entry restarts start-up counters from zero
module cssc_top
  import cssc_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire cssc_pkg::cssc_fuse_t fuses, // Raw fuse values
  input wire logic src_tick, // Selected source clock level
  input wire logic wdt_osc, // Watchdog oscillator level
  input wire logic sleep_req, // Request sleep entry
  input wire cssc_pkg::cssc_sleep_t sleep_mode, // Requested sleep mode
  input wire logic wake, // Wake event, level or pulse
  output cssc_pkg::cssc_src_t source, // Decoded clock source
  output logic cfg_error, // Reserved select or start-up code
  output logic exec_en, // Instruction execution allowed
  output cssc_pkg::cssc_gate_t gate // Domain enables
);
  `include "cssc_map.svh"

  // ************************************
  // Fuse capture and decode
  // ************************************
  typedef enum {
    ST_LOAD,
    ST_RST_CK,
    ST_RST_WDT,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE
  } cssc_st_t;

  function automatic cssc_src_t decode_src(input logic [3:0] sel);
    cssc_src_t s;
    s = CSSC_SRC_NONE;
    if (sel[3]) begin
      s = CSSC_SRC_XTAL; // R01
    end else begin
      case (sel)
        `CSSC_SRC_EXT: s = CSSC_SRC_EXTCLK; // R01
        `CSSC_SRC_RC8M: s = CSSC_SRC_INT8M;
        `CSSC_SRC_RC128K: s = CSSC_SRC_INT128K;
        `CSSC_SRC_LFXTAL: s = CSSC_SRC_LFX;
        default: s = CSSC_SRC_NONE;
      endcase
    end
    return s;
  endfunction

  function automatic logic [CNT_W-1:0] wdt_len(input logic [1:0] startup_time_fuses);
    logic [CNT_W-1:0] n;
    n = '0;
    case (startup_time_fuses)
      `CSSC_SUT_4MS: n = CNT_W'(`CSSC_WDT_4MS); // R05
      `CSSC_SUT_64MS: n = CNT_W'(`CSSC_WDT_64MS); // R05
      default: n = '0;
    endcase
    return n;
  endfunction

  cssc_st_t st_q, st_d;
  cssc_fuse_t fuse_q, fuse_d;
  cssc_src_t src_q, src_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] wdt_q, wdt_d;
  logic err_q, err_d;
  logic exec_q, exec_d;
  logic [1:0] mode_q, mode_d;
  logic src_rise, wdt_rise;

  // Fuses are held as raw bits; 0 means programmed, so codes read directly
  cssc_edge u_src_edge (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick_in(src_tick),
    .rise(src_rise)
  );

  cssc_edge u_wdt_edge (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick_in(wdt_osc),
    .rise(wdt_rise)
  );

  // ************************************
  // Start-up sequencer
  // ************************************
  always_comb begin
    st_d = st_q;
    fuse_d = fuse_q;
    src_d = src_q;
    cnt_d = cnt_q;
    wdt_d = wdt_q;
    err_d = err_q;
    exec_d = 1'b0;
    mode_d = mode_q;
    case (st_q)
      ST_LOAD: begin
        // Fuses sampled once after reset release
        fuse_d = fuses; // R02
        src_d = decode_src(fuses.sel);
        err_d = (decode_src(fuses.sel) == CSSC_SRC_NONE) || (fuses.startup_time_fuses == 2'h3); // R01
        cnt_d = '0; // R14
        wdt_d = '0;
        st_d = ST_RST_CK;
      end
      ST_RST_CK: begin
        if (src_rise) begin
          cnt_d = cnt_q + CNT_W'(1);
        end
        if (src_rise && (cnt_q + CNT_W'(1) >= CNT_W'(`CSSC_RST_CYCLES))) begin // R06
          cnt_d = '0;
          st_d = ST_RST_WDT;
        end
      end
      ST_RST_WDT: begin
        // Real-time part counted on watchdog oscillator, not the source
        if (wdt_q >= wdt_len(fuse_q.startup_time_fuses)) begin // R04
          st_d = ST_RUN;
        end else if (wdt_rise) begin
          wdt_d = wdt_q + CNT_W'(1); // R04
        end
      end
      ST_RUN: begin
        exec_d = 1'b1;
        if (sleep_req) begin
          mode_d = sleep_mode;
          exec_d = 1'b0;
          st_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        cnt_d = '0; // R14
        if (wake) begin
          if (cssc_sleep_t'(mode_q) == CSSC_SLEEP_PWRDN) begin
            st_d = ST_WAKE;
          end else begin
            st_d = ST_RUN;
          end
        end
      end
      ST_WAKE: begin
        if (sleep_req) begin
          mode_d = sleep_mode;
          cnt_d = '0; // R14
          st_d = ST_SLEEP;
        end else if (src_rise) begin
          cnt_d = cnt_q + CNT_W'(1); // R03
          if (cnt_q + CNT_W'(1) >= CNT_W'(`CSSC_PD_CYCLES)) begin // R06
            cnt_d = '0;
            st_d = ST_RUN;
          end
        end
      end
      default: begin
        st_d = ST_LOAD;
      end
    endcase
  end

  // Reset always restarts from ST_LOAD with zeroed counters
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_LOAD; // R14
      fuse_q <= '{sel: `CSSC_SEL_RESET, startup_time_fuses: `CSSC_SUT_RESET};
      src_q <= CSSC_SRC_NONE;
      cnt_q <= '0;
      wdt_q <= '0;
      err_q <= 1'b0;
      exec_q <= 1'b0;
      mode_q <= 2'h0;
    end else begin
      st_q <= st_d;
      fuse_q <= fuse_d;
      src_q <= src_d;
      cnt_q <= cnt_d;
      wdt_q <= wdt_d;
      err_q <= err_d;
      exec_q <= exec_d;
      mode_q <= mode_d;
    end
  end

  // ************************************
  // Domain gating
  // ************************************
  // Core and program memory off whenever execution is held, except the first cycle after sleep entry
  cssc_gate u_gate (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .running((st_q == ST_RUN) || (st_q == ST_SLEEP)), // R09
    .asleep(st_q == ST_SLEEP),
    .mode(cssc_sleep_t'(mode_q)),
    .gate(gate)
  );

  assign source = src_q;
  assign cfg_error = err_q;
  assign exec_en = exec_q;
endmodule

// ===== tb/cssc_monitor.sv
// Timing and gating checks for the clock start-up block
module cssc_monitor
  import cssc_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Async reset
  input wire cssc_pkg::cssc_fuse_t fuses, // Fuses
  input wire logic sleep_req, // Sleep request
  input wire cssc_pkg::cssc_sleep_t sleep_mode, // Sleep mode
  input wire logic wake, // Wake event
  input wire logic exec_en, // Execution allowed
  input wire cssc_pkg::cssc_gate_t gate // Domain enables
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cyc_q, cyc_d, slp_q, slp_d;
  logic up_q, up_d;
  cssc_sleep_t mode_q, mode_d;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Bounds assume each counted edge spans four or more cycles
  function automatic logic [15:0] min_cyc(input logic [1:0] startup_time_fuses);
    return (startup_time_fuses == 2'h1) ? 16'h0830 : (startup_time_fuses == 2'h2) ? 16'h8030 : 16'h0034;
  endfunction
  always_comb begin
    cyc_d = (cyc_q == 16'hffff) ? cyc_q : cyc_q + 16'h0001;
    slp_d = (exec_en || wake) ? 16'h0000 : slp_q + 16'h0001;
    up_d = up_q | exec_en;
    mode_d = (exec_en && sleep_req) ? sleep_mode : mode_q;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_q <= '0;
      slp_q <= '0;
      up_q <= 1'b0;
      mode_q <= CSSC_SLEEP_IDLE;
    end else begin
      cyc_q <= cyc_d;
      slp_q <= slp_d;
      up_q <= up_d;
      mode_q <= mode_d;
    end
  end
  chk_reset_delay: assert property (
    $rose(exec_en) && !up_q |-> cyc_q >= min_cyc(fuses.startup_time_fuses)) else $error("start before delay");
  chk_pd_wake: assert property (
    $rose(exec_en) && up_q && mode_q == CSSC_SLEEP_PWRDN |-> slp_q >= 16'h0014) else $error("fast wake");
  chk_quick_wake: assert property (
    wake && !exec_en && up_q && mode_q != CSSC_SLEEP_PWRDN |-> ##[1:4] exec_en) else $error("late wake");
  chk_exec_drop: assert property (exec_en && sleep_req |=> !exec_en) else $error("still running");
  chk_run_gates: assert property (
    exec_en && $past(exec_en) && $past(exec_en, 2) |-> gate == 4'hf) else $error("domain off in run");
  chk_flash_core: assert property (gate.progmem == gate.core) else $error("flash apart from core");
  chk_conv_own: assert property (gate.periph |-> gate.conv) else $error("converter halted");
  chk_core_periph: assert property (gate.core |-> gate.periph) else $error("io halted in run");
  cover property ($rose(exec_en) && mode_q == CSSC_SLEEP_PWRDN);
  cover property (gate == 4'h1);
  cover property (!up_q && $rose(exec_en) && fuses.startup_time_fuses == 2'h2);
endmodule
bind cssc_top cssc_monitor monitor (.sys_clk(sys_clk), .rst_n(rst_n), .fuses(fuses), .sleep_req(sleep_req),
  .sleep_mode(sleep_mode), .wake(wake), .exec_en(exec_en), .gate(gate));

// ===== tb/cssc_osc_model.sv
// Free-running oscillator model for the source and watchdog inputs
module cssc_osc_model #(
  parameter int HALF_NS = 230, // Half period
  parameter int PHASE_NS = 13 // Start offset, keeps edges off the clock
) (
  output logic tick // Oscillator level
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    tick = 1'b0;
    #(PHASE_NS);
    // Fixed period, so no cycle-to-cycle drift at all
    forever #(HALF_NS) tick = ~tick;
  end
endmodule

// ===== tb/tb_clock_source_startup_control.sv
// Testbench for the clock source and start-up control block
module tb_clock_source_startup_control
  import cssc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst_n, src_tick, wdt_osc, sleep_req, wake, cfg_error, exec_en;
  cssc_fuse_t fuses;
  cssc_sleep_t sleep_mode;
  cssc_src_t source;
  cssc_gate_t gate;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [3:0] sel_tbl [6] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h1, 4'h8};
  logic [1:0] sut_tbl [6] = '{2'h1, 2'h0, 2'h3, 2'h1, 2'h0, 2'h2};
  logic [3:0] sel;
  cssc_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .fuses(fuses), .src_tick(src_tick), .wdt_osc(wdt_osc),
    .sleep_req(sleep_req), .sleep_mode(sleep_mode), .wake(wake), .source(source), .cfg_error(cfg_error),
    .exec_en(exec_en), .gate(gate));
  cssc_osc_model #(.HALF_NS(230), .PHASE_NS(13)) src_osc (.tick(src_tick));
  cssc_osc_model #(.HALF_NS(270), .PHASE_NS(27)) watchdog_osc (.tick(wdt_osc));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  function automatic cssc_src_t exp_src(input logic [3:0] s);
    if (s[3]) return CSSC_SRC_XTAL;
    case (s)
      4'h0: return CSSC_SRC_EXTCLK;
      4'h2: return CSSC_SRC_INT8M;
      4'h4: return CSSC_SRC_INT128K;
      4'h6: return CSSC_SRC_LFX;
      default: return CSSC_SRC_NONE;
    endcase
  endfunction
  function automatic logic [3:0] exp_gate(input cssc_sleep_t m);
    return (m == CSSC_SLEEP_IDLE) ? 4'h5 : (m == CSSC_SLEEP_NOISE) ? 4'h1 : 4'h0;
  endfunction
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [3:0] s, input logic [1:0] t);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    fuses <= '{sel: s, startup_time_fuses: t};
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask
  task automatic wait_run();
    for (int k = 0; k < 50000 && exec_en !== 1'b1; k++) @(negedge sys_clk);
    check({3'h0, exec_en}, 4'h1);
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    rst_n = 1'b0;
    fuses = '0;
    sleep_req = 1'b0;
    sleep_mode = CSSC_SLEEP_IDLE;
    wake = 1'b0;
    void'($urandom(32'hbbf1_69ee));
    do_reset(4'h2, 2'h1);
    repeat (120) @(posedge sys_clk);
    for (int i = 0; i < 6; i++) begin
      sel = (i == 5) ? 4'(8 + $urandom_range(7)) : sel_tbl[i];
      do_reset(sel, sut_tbl[i]);
      wait_run();
      check({1'b0, source}, {1'b0, exp_src(sel)});
      check({3'h0, cfg_error}, {3'h0, exp_src(sel) == CSSC_SRC_NONE || sut_tbl[i] == 2'h3});
      for (int m = 0; m < 4; m++) begin
        @(posedge sys_clk);
        sleep_req <= 1'b1;
        sleep_mode <= cssc_sleep_t'(m);
        @(posedge sys_clk);
        sleep_req <= 1'b0;
        repeat (3) @(negedge sys_clk);
        check({3'h0, exec_en}, 4'h0);
        check(gate, exp_gate(cssc_sleep_t'(m)));
        repeat ($urandom_range(20, 2)) @(posedge sys_clk);
        wake <= 1'b1;
        @(posedge sys_clk);
        wake <= 1'b0;
        if (m == 3) begin
          // Back to sleep before the wake count ends; the count must restart
          repeat (5) @(posedge sys_clk);
          sleep_req <= 1'b1;
          @(posedge sys_clk);
          sleep_req <= 1'b0;
          repeat (3) @(negedge sys_clk);
          check({3'h0, exec_en}, 4'h0);
          check(gate, 4'h0);
          @(posedge sys_clk);
          wake <= 1'b1;
          @(posedge sys_clk);
          wake <= 1'b0;
        end
        wait_run();
        repeat (2) @(negedge sys_clk);
        check(gate, 4'hf);
      end
    end
    conclude();
  end
endmodule
